// ===== logic/adc_seq_pkg.sv
// Constants and types shared by the converter sequencing control
package adc_seq_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam logic [14:0] IDX_RESULT    = 15'h1faa;
    localparam logic [14:0] IDX_COMMAND   = 15'h1fac;
    localparam logic [14:0] IDX_TEST      = 15'h1fae;
    localparam logic [14:0] IDX_TIMING    = 15'h1faf;
    localparam logic [14:0] IDX_THRESHOLD = 15'h1fb0;

    ////////////////////////////////////////////////////////////////////////////////
    // Command fields
    localparam int CMD_CHAN_LSB = 0;
    localparam int CMD_CHAN_MSB = 2;
    localparam int CMD_GO_BIT   = 3;
    localparam int CMD_MODE_BIT = 4;
    localparam int CMD_THR_BIT  = 5;

    // Test fields
    localparam int TST_EN_BIT   = 0;
    localparam int TST_VREF_BIT = 1;
    localparam int TST_OFS_LSB  = 2;
    localparam int TST_OFS_MSB  = 3;
    localparam logic [1:0] OFS_PLUS  = 2'h1;
    localparam logic [1:0] OFS_MINUS = 2'h2;

    // Timing fields
    localparam int TIM_SAM_LSB  = 5;
    localparam int TIM_SAM_MSB  = 7;
    localparam int TIM_BIT_TIME_SETTING_LSB = 0;
    localparam int TIM_BIT_TIME_SETTING_MSB = 4;

    // Result word layout
    localparam int RES_BUSY_BIT  = 3;
    localparam int RES_VALUE_LSB = 6;

    // Reset values
    localparam logic [7:0] CMD_RESET    = 8'h00;
    localparam logic [7:0] TEST_RESET   = 8'h00;
    localparam logic [7:0] TIMING_RESET = 8'hff;
    localparam logic [9:0] THR_RESET    = 10'h3ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing in state times; one state is one clock of 20 MHz
    localparam int CLK_MHZ          = 20;
    localparam int STATE_NS         = 50;
    localparam int CYC_PER_STATE    = (STATE_NS * CLK_MHZ + 999) / 1000;
    localparam int SAMPLE_MULT      = 4;
    localparam int SAMPLE_ADD       = 1;
    localparam int FINISH_HALF      = 3;
    localparam int FINISH_CYC       = (FINISH_HALF * CYC_PER_STATE + 1) / 2;
    localparam int BUSY_DELAY_STATE = 8;
    localparam int BUSY_DELAY_CYC   = BUSY_DELAY_STATE * CYC_PER_STATE;
    localparam int RES_BITS_FULL    = 10;
    localparam int RES_BITS_SHORT   = 8;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARMED,
        ST_SAMPLE,
        ST_CONVERT,
        ST_FINISH
    } seq_state_t;

endpackage

// ===== logic/sar_approx.sv
// Successive-approximation trial register
`timescale 1ns/10ps
module sar_approx #(
    parameter int WIDTH = 10
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Control
    input  wire logic             load_i,
    input  wire logic             short_i,
    input  wire logic             decide_i,
    input  wire logic             comp_i,
    // Trial and outcome
    output logic [WIDTH-1:0]      trial_o,
    output logic                  last_o
);

    initial begin
        if (WIDTH < 3) begin
            $error("sar_approx needs at least three bits");
        end
    end

    typedef struct packed {
        logic [WIDTH-1:0] value;
        logic [WIDTH-1:0] mask;
    } sar_t;

    sar_t st_reg;
    sar_t st_next;
    logic [WIDTH-1:0] stop_mask;

    // Lowest decided bit depends on resolution
    assign stop_mask = short_i ? {{(WIDTH-3){1'b0}}, 3'h4} : {{(WIDTH-1){1'b0}}, 1'b1};
    assign trial_o   = st_reg.value;
    assign last_o    = (st_reg.mask == stop_mask);

    // Keep or drop the trial bit, then try the next one
    always_comb begin
        st_next = st_reg;
        if (load_i) begin
            st_next.mask  = {1'b1, {(WIDTH-1){1'b0}}};
            st_next.value = {1'b1, {(WIDTH-1){1'b0}}};
        end else if (decide_i) begin
            if (!comp_i) begin
                st_next.value = st_reg.value & ~st_reg.mask;
            end
            if (st_reg.mask != stop_mask) begin
                st_next.mask  = st_reg.mask >> 1;
                st_next.value = st_next.value | (st_reg.mask >> 1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule

// ===== logic/adc_sequencing_control.sv
// Sequencing control of the eight-channel successive-approximation converter
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/10ps
module adc_sequencing_control #(
    parameter int ADR_W = 17
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Wishbone slave
    input  wire logic             cyc_i,
    input  wire logic             stb_i,
    input  wire logic             we_i,
    input  wire logic [ADR_W-1:0] adr_i,
    input  wire logic [3:0]       sel_i,
    input  wire logic [31:0]      dat_i,
    output logic [31:0]           dat_o,
    output logic                  ack_o,
    // Event processor array start
    input  wire logic             event_processor_array_i,
    // Analog front end
    input  wire logic             comp_i,
    output logic [2:0]            mux_sel_o,
    output logic                  test_en_o,
    output logic                  vref_sel_o,
    output logic                  sample_o,
    output logic [9:0]            trial_o,
    // Events
    output logic                  bit_time_setting_done_o,
    output logic                  threshold_hit_o
);

    // Refuse an address bus too narrow for the indices
    initial begin
        if (ADR_W < 17) begin
            $error("address too narrow for the register indices");
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State

    // All state of the block except the trial register in u_sar, in one packed word
    typedef struct packed {
        adc_seq_pkg::seq_state_t fsm;
        logic [7:0]  cmd;
        logic [7:0]  test;
        logic [7:0]  timing;
        logic [9:0]  thresh;
        logic [9:0]  value;
        logic [2:0]  chan;
        logic        busy;
        logic [7:0]  cnt;
        logic [3:0]  busy_cnt;
        logic        ack;
        logic [31:0] rdat;
        logic        done;
        logic        hit;
        logic        comp_meta;
        logic        comp_sync;
    } ctl_t;

    // Registered state and its next value
    ctl_t st_reg;
    ctl_t st_next;

    // Decode, datapath and trial register nets
    logic       access;
    logic       wr_go;
    logic [14:0] idx;
    logic [2:0] sam;
    logic [4:0] bit_time_setting;
    logic       short_mode;
    logic       thr_mode;
    logic       sar_load;
    logic       sar_decide;
    logic       sar_last;
    logic [9:0] sar_trial;
    logic [9:0] adj_value;
    logic [15:0] result_word;
    logic [7:0] sample_end;

    ////////////////////////////////////////////////////////////////////////////////
    // Decode

    // Bus decode; writes land on the acknowledge edge
    assign access = cyc_i & stb_i;
    assign wr_go  = access & we_i & st_reg.ack & sel_i[0];
    assign idx    = adr_i[16:2];

    assign sam              = st_reg.timing[adc_seq_pkg::TIM_SAM_MSB:adc_seq_pkg::TIM_SAM_LSB];
    assign bit_time_setting = st_reg.timing[adc_seq_pkg::TIM_BIT_TIME_SETTING_MSB:adc_seq_pkg::TIM_BIT_TIME_SETTING_LSB];
    assign short_mode = st_reg.cmd[adc_seq_pkg::CMD_MODE_BIT] & ~thr_mode;
    assign thr_mode   = st_reg.cmd[adc_seq_pkg::CMD_THR_BIT];

    assign sample_end = 8'(adc_seq_pkg::SAMPLE_MULT * sam + adc_seq_pkg::SAMPLE_ADD - 1);

    always_comb begin
        adj_value = st_reg.value;
        case (st_reg.test[adc_seq_pkg::TST_OFS_MSB:adc_seq_pkg::TST_OFS_LSB])
            adc_seq_pkg::OFS_PLUS: begin
                if (st_reg.value != 10'h3ff) begin
                    adj_value = st_reg.value + 10'h001;
                end
            end
            adc_seq_pkg::OFS_MINUS: begin
                if (st_reg.value != 10'h000) begin
                    adj_value = st_reg.value - 10'h001;
                end
            end
            default: adj_value = st_reg.value;
        endcase
    end

    assign result_word = {adj_value, 2'h0, st_reg.busy, st_reg.chan};

    // Front-end drive
    // channel to multiplexer
    assign mux_sel_o  = st_reg.cmd[adc_seq_pkg::CMD_CHAN_MSB:adc_seq_pkg::CMD_CHAN_LSB];
    assign test_en_o  = st_reg.test[adc_seq_pkg::TST_EN_BIT];
    assign vref_sel_o = st_reg.test[adc_seq_pkg::TST_VREF_BIT];
    // Phase and bus outputs straight from registered state
    assign sample_o   = (st_reg.fsm == adc_seq_pkg::ST_SAMPLE);
    assign trial_o    = sar_trial;
    assign dat_o      = st_reg.rdat;
    assign ack_o      = st_reg.ack;
    assign bit_time_setting_done_o     = st_reg.done;
    assign threshold_hit_o = st_reg.hit;

    // Trial register of the successive approximation
    sar_approx #(
        .WIDTH (adc_seq_pkg::RES_BITS_FULL)
    ) u_sar (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .load_i   (sar_load),
        .short_i  (short_mode),
        .decide_i (sar_decide),
        .comp_i   (st_reg.comp_sync),
        .trial_o  (sar_trial),
        .last_o   (sar_last)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_next    = st_reg;
        sar_load   = 1'b0;
        sar_decide = 1'b0;
        st_next.done = 1'b0;
        st_next.hit  = 1'b0;

        // Comparator synchroniser
        st_next.comp_meta = comp_i;
        st_next.comp_sync = st_reg.comp_meta;

        // Bus answer one cycle after request
        st_next.ack = access & ~st_reg.ack;
        // Read data registered so it stands with ack
        st_next.rdat = 32'h0000_0000;
        case (idx)
            adc_seq_pkg::IDX_RESULT:    st_next.rdat = {16'h0000, result_word};
            adc_seq_pkg::IDX_COMMAND:   st_next.rdat = {24'h000000, st_reg.cmd};
            adc_seq_pkg::IDX_TEST:      st_next.rdat = {24'h000000, st_reg.test};
            adc_seq_pkg::IDX_TIMING:    st_next.rdat = {24'h000000, st_reg.timing};
            adc_seq_pkg::IDX_THRESHOLD: st_next.rdat = {22'h000000, st_reg.thresh};
            default:                    st_next.rdat = 32'h0000_0000;
        endcase

        // busy rises after fixed delay from start
        if (st_reg.fsm == adc_seq_pkg::ST_SAMPLE || st_reg.fsm == adc_seq_pkg::ST_CONVERT ||
            st_reg.fsm == adc_seq_pkg::ST_FINISH) begin
            if (st_reg.busy_cnt == 4'(adc_seq_pkg::BUSY_DELAY_CYC - 1)) begin
                st_next.busy = 1'b1;
            end else begin
                st_next.busy_cnt = st_reg.busy_cnt + 4'h1;
            end
        end

        // Conversion sequencer
        case (st_reg.fsm)
            adc_seq_pkg::ST_IDLE: begin
                // Nothing to do until a command arrives
                st_next.cnt = 8'h00;
            end
            adc_seq_pkg::ST_ARMED: begin
                // first trigger starts, later ones fall in busy states
                if (event_processor_array_i) begin
                    st_next.fsm      = adc_seq_pkg::ST_SAMPLE;
                    st_next.cnt      = 8'h00;
                    st_next.busy_cnt = 4'h0;
                end
            end
            adc_seq_pkg::ST_SAMPLE: begin
                // hold sample for four times setting plus one
                if (st_reg.cnt >= sample_end) begin
                    st_next.fsm = adc_seq_pkg::ST_CONVERT;
                    st_next.cnt = 8'h00;
                    sar_load    = 1'b1;
                end else begin
                    st_next.cnt = st_reg.cnt + 8'h01;
                end
            end
            adc_seq_pkg::ST_CONVERT: begin
                // each bit takes setting plus one states
                // Comparator reaches the sync two edges late
                if (st_reg.cnt >= {3'h0, bit_time_setting}) begin
                    sar_decide  = 1'b1;
                    st_next.cnt = 8'h00;
                    if (sar_last) begin
                        st_next.fsm = adc_seq_pkg::ST_FINISH;
                    end
                end else begin
                    st_next.cnt = st_reg.cnt + 8'h01;
                end
            end
            adc_seq_pkg::ST_FINISH: begin
                // trailing one and a half states
                if (st_reg.cnt >= 8'(adc_seq_pkg::FINISH_CYC - 1)) begin
                    // store result, clear busy, one done pulse unless in threshold mode
                    st_next.value = sar_trial;
                    st_next.chan  = mux_sel_o;
                    st_next.busy  = 1'b0;
                    st_next.busy_cnt = 4'h0;
                    st_next.cnt   = 8'h00;
                    st_next.fsm   = adc_seq_pkg::ST_IDLE;
                    if (!thr_mode) begin
                        st_next.done = 1'b1;
                    end else if (st_reg.cmd[adc_seq_pkg::CMD_MODE_BIT] ?
                                 (sar_trial < st_reg.thresh) :
                                 (sar_trial > st_reg.thresh)) begin
                        st_next.hit = 1'b1;
                    end else begin
                        // Keep watching the input
                        st_next.fsm = adc_seq_pkg::ST_SAMPLE;
                    end
                end else begin
                    st_next.cnt = st_reg.cnt + 8'h01;
                end
            end
            default: begin
                st_next.fsm = adc_seq_pkg::ST_IDLE;
            end
        endcase

        // Register writes take effect on the acknowledge edge
        if (wr_go) begin
            case (idx)
                adc_seq_pkg::IDX_COMMAND: begin
                    st_next.cmd = dat_i[7:0];
                    st_next.cnt = 8'h00;
                    // a write aborts any conversion; the busy delay restarts only from idle or armed
                    if (st_reg.fsm == adc_seq_pkg::ST_IDLE ||
                        st_reg.fsm == adc_seq_pkg::ST_ARMED) begin
                        st_next.busy_cnt = 4'h0;
                    end
                    if (dat_i[adc_seq_pkg::CMD_GO_BIT]) begin
                        // start on the very next edge
                        st_next.fsm = adc_seq_pkg::ST_SAMPLE;
                    end else begin
                        // wait for the event processor array
                        st_next.fsm = adc_seq_pkg::ST_ARMED;
                    end
                end
                // Test and timing keep the low byte as written; threshold takes ten bits when sel_i[1] is set
                adc_seq_pkg::IDX_TEST:      st_next.test   = dat_i[7:0];
                adc_seq_pkg::IDX_TIMING:    st_next.timing = dat_i[7:0];
                adc_seq_pkg::IDX_THRESHOLD: begin
                    if (sel_i[1]) begin
                        st_next.thresh = dat_i[9:0];
                    end
                end
                default: st_next.cmd = st_reg.cmd;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    // Synchronous reset loads the defaults
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg        <= '0;
            st_reg.fsm    <= adc_seq_pkg::ST_IDLE;
            st_reg.cmd    <= adc_seq_pkg::CMD_RESET;
            st_reg.test   <= adc_seq_pkg::TEST_RESET;
            st_reg.timing <= adc_seq_pkg::TIMING_RESET;
            st_reg.thresh <= adc_seq_pkg::THR_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule

// ===== verification/adc_seq_checker.sv
// Port-level assertions for the converter sequencing control
`timescale 1ns/10ps
module adc_seq_checker #(
    parameter int ADR_W = 17
) (
    // Clock and reset
    input wire logic             clk_i,
    input wire logic             rst_i,
    // Wishbone slave
    input wire logic             cyc_i,
    input wire logic             stb_i,
    input wire logic             we_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [3:0]       sel_i,
    input wire logic [31:0]      dat_i,
    input wire logic [31:0]      dat_o,
    input wire logic             ack_o,
    // Start trigger and front end
    input wire logic             event_processor_array_i,
    input wire logic             comp_i,
    input wire logic [2:0]       mux_sel_o,
    input wire logic             test_en_o,
    input wire logic             vref_sel_o,
    input wire logic             sample_o,
    input wire logic [9:0]       trial_o,
    // Events
    input wire logic             bit_time_setting_done_o,
    input wire logic             threshold_hit_o
);
    logic [7:0] cmd_m;
    logic [7:0] tim_m;
    logic       armed_q;
    logic [5:0] samp_cnt;
    logic [9:0] bit_time_setting_cnt;
    logic       wr;
    logic       wr_cmd;
    logic       wr_tst;
    logic       wr_tim;
    logic       rd_res;
    int         bit_time_setting_lo;

    // Decoded bus transfers at the acknowledge edge
    assign wr      = cyc_i && stb_i && ack_o && we_i && sel_i[0];
    assign wr_cmd  = wr && adr_i[ADR_W-1:2] == adc_seq_pkg::IDX_COMMAND;
    assign wr_tst  = wr && adr_i[ADR_W-1:2] == adc_seq_pkg::IDX_TEST;
    assign wr_tim  = wr && adr_i[ADR_W-1:2] == adc_seq_pkg::IDX_TIMING;
    assign rd_res  = cyc_i && stb_i && ack_o && !we_i
                     && adr_i[ADR_W-1:2] == adc_seq_pkg::IDX_RESULT;
    assign bit_time_setting_lo = (cmd_m[4] ? 8 : 10) * (tim_m[4:0] + 1) + 1;

    // Mirrors of written settings and phase counters
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_m    <= 8'h00;
            tim_m    <= 8'hff;
            armed_q  <= 1'h0;
            samp_cnt <= 6'h00;
            bit_time_setting_cnt <= 10'h000;
        end else begin
            if (wr_cmd) cmd_m <= dat_i[7:0];
            if (wr_tim) tim_m <= dat_i[7:0];
            if (wr_cmd) armed_q <= !dat_i[3];
            else if (event_processor_array_i) armed_q <= 1'h0;
            samp_cnt <= sample_o ? samp_cnt + 6'h01 : 6'h00;
            bit_time_setting_cnt <= sample_o ? 10'h000 : bit_time_setting_cnt + {9'h000, bit_time_setting_cnt != 10'h3ff};
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_req; cyc_i && stb_i && !ack_o; endsequence
    sequence s_ack; ack_o ##1 !ack_o; endsequence
    property p_ack; s_req |=> s_ack; endproperty
    a_ack: assert property (p_ack) else $error("ack missing or held");
    property p_go; wr_cmd && dat_i[3] |-> ##[1:3] sample_o; endproperty
    a_go: assert property (p_go) else $error("no prompt start");
    property p_arm; wr_cmd && !dat_i[3] |=> !sample_o; endproperty
    a_arm: assert property (p_arm) else $error("started without trigger");
    property p_trig; armed_q && event_processor_array_i |=> sample_o; endproperty
    a_trig: assert property (p_trig) else $error("trigger ignored");
    property p_mux; wr_cmd |=> mux_sel_o == $past(dat_i[2:0]); endproperty
    a_mux: assert property (p_mux) else $error("channel select wrong");
    property p_tst;
        wr_tst |=> test_en_o == $past(dat_i[0]) && vref_sel_o == $past(dat_i[1]);
    endproperty
    a_tst: assert property (p_tst) else $error("test select wrong");
    property p_samp; $fell(sample_o) |-> samp_cnt == 4 * tim_m[7:5] + 1; endproperty
    a_samp: assert property (p_samp) else $error("sample length wrong");
    property p_bit_time_setting; bit_time_setting_done_o |-> bit_time_setting_cnt >= bit_time_setting_lo && bit_time_setting_cnt <= bit_time_setting_lo + 2; endproperty
    a_bit_time_setting: assert property (p_bit_time_setting) else $error("convert length wrong");
    sequence s_once(sig); !sig; endsequence
    property p_done; bit_time_setting_done_o |-> !cmd_m[5] ##1 s_once(bit_time_setting_done_o); endproperty
    a_done: assert property (p_done) else $error("bad done pulse");
    property p_abort; wr_cmd |=> !bit_time_setting_done_o [*8]; endproperty
    a_abort: assert property (p_abort) else $error("done after restart");
    property p_hit; threshold_hit_o |-> cmd_m[5] ##1 s_once(threshold_hit_o); endproperty
    a_hit: assert property (p_hit) else $error("bad threshold pulse");
    property p_res; rd_res |-> dat_o[5:4] == 2'h0 && dat_o[31:16] == 16'h0000; endproperty
    a_res: assert property (p_res) else $error("result spare bits set");
endmodule

bind adc_sequencing_control adc_seq_checker #(.ADR_W(ADR_W)) chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .event_processor_array_i(event_processor_array_i), .comp_i(comp_i),
    .mux_sel_o(mux_sel_o), .test_en_o(test_en_o), .vref_sel_o(vref_sel_o),
    .sample_o(sample_o), .trial_o(trial_o), .bit_time_setting_done_o(bit_time_setting_done_o),
    .threshold_hit_o(threshold_hit_o));

// ===== verification/afe_model.sv
// Behavioural analog front end: levels, sample hold, comparator
`timescale 1ns/10ps
module afe_model (
    // Channel levels
    input wire logic [7:0][9:0] level_i,
    // From the block
    input wire logic [2:0]      mux_sel_i,
    input wire logic            test_en_i,
    input wire logic            vref_sel_i,
    input wire logic            sample_i,
    input wire logic [9:0]      trial_i,
    // Comparator
    output logic                comp_o
);
    logic [9:0] src;
    logic [9:0] held = 10'h000;

    always_comb begin
        if (test_en_i) src = vref_sel_i ? 10'h3ff : 10'h000;
        else src = level_i[mux_sel_i];
    end
    always @(src or sample_i) if (sample_i) held = src;
    // Comparator against trial code
    assign comp_o = held >= trial_i;
endmodule

// ===== verification/adc_sequencing_control_bench.sv
// Self-checking bench for the converter sequencing control
`timescale 1ns/10ps
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin bad_count++; \
    $display("BAD %0t %s", $time, m); end end
module adc_sequencing_control_bench;
    localparam logic [14:0] CMD = adc_seq_pkg::IDX_COMMAND;
    localparam logic [14:0] RES = adc_seq_pkg::IDX_RESULT;
    localparam logic [14:0] TST = adc_seq_pkg::IDX_TEST;
    localparam logic [14:0] TIM = adc_seq_pkg::IDX_TIMING;
    logic            clk_i = 1'h0;
    logic            rst_i = 1'h1;
    logic            cyc_i = 1'h0;
    logic            stb_i = 1'h0;
    logic            we_i  = 1'h0;
    logic            trig  = 1'h0;
    logic [16:0]     adr_i = 17'h00000;
    logic [3:0]      sel_i = 4'h0;
    logic [31:0]     dat_i = 32'h0;
    logic [31:0]     dat_o, q;
    logic            ack_o, comp, samp, ten, vsel, done, hit;
    logic [2:0]      mux;
    logic [9:0]      trial;
    logic [7:0][9:0] lvl = '0;
    int              bad_count = 0, compares = 0, dones = 0, hits = 0, c0, h0;

    always #25 clk_i = ~clk_i;

    adc_sequencing_control dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .event_processor_array_i(trig), .comp_i(comp), .mux_sel_o(mux),
        .test_en_o(ten), .vref_sel_o(vsel), .sample_o(samp), .trial_o(trial),
        .bit_time_setting_done_o(done), .threshold_hit_o(hit));
    afe_model afe (.level_i(lvl), .mux_sel_i(mux), .test_en_i(ten), .vref_sel_i(vsel),
        .sample_i(samp), .trial_i(trial), .comp_o(comp));

    // Event pulse counters
    always @(posedge clk_i) begin
        if (done === 1'b1) dones++;
        if (hit === 1'b1) hits++;
    end

    task tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // One classic Wishbone cycle, held until ack
    task automatic wb(input logic w, input logic [14:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= {idx, 2'h0};
        sel_i <= 4'hf;
        dat_i <= d;
        do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 40);
        q = dat_o;
        if (n >= 40) `CHK(1'b0, 1'b1, "no ack")
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    // Wait for a done (h=0) or hit (h=1) pulse
    task automatic wait_ev(input bit h, input int lim);
        int e0, n;
        e0 = h ? hits : dones;
        n = 0;
        while ((h ? hits : dones) == e0 && n < lim) begin @(posedge clk_i); n++; end
        if (n >= lim) `CHK(1'b0, 1'b1, "event timeout")
    endtask

    task t_regs;
        wb(1'b0, CMD, 32'h0); `CHK(q, 32'h0, "command reset")
        wb(1'b0, TIM, 32'h0); `CHK(q, 32'h000000ff, "timing reset")
        wb(1'b1, TIM, 32'h22); wb(1'b0, TIM, 32'h0);
        `CHK(q, 32'h22, "timing rw")
        wb(1'b1, RES, 32'hffff); wb(1'b0, RES, 32'h0);
        `CHK(q, 32'h0, "result ro")
        wb(1'b0, 15'h0010, 32'h0); `CHK(q, 32'h0, "unmapped read")
        $display("registers test done");
    endtask

    task t_norm;
        lvl[5] = 10'h2b7;
        lvl[3] = 10'h1e6;
        wb(1'b1, CMD, 32'h0d); tick(12); `CHK(mux, 3'h5, "channel")
        wb(1'b0, RES, 32'h0); `CHK(q[3], 1'b1, "busy")
        wait_ev(1'b0, 600); tick(2);
        `CHK(trial, 10'h2b7, "final trial")
        wb(1'b0, RES, 32'h0);
        `CHK(q[15:0], ({10'h2b7, 6'h05}), "full result")
        wb(1'b1, CMD, 32'h1b); wait_ev(1'b0, 600); tick(2);
        wb(1'b0, RES, 32'h0);
        `CHK(q[15:0], ({10'h1e4, 6'h03}), "short result")
        $display("normal conversion test done");
    endtask

    task t_arm;
        lvl[6] = 10'h0f3;
        wb(1'b1, CMD, 32'h06); tick(6); `CHK(samp, 1'b0, "armed start")
        c0 = dones;
        trig <= 1'b1; tick(1); trig <= 1'b0; tick(12);
        trig <= 1'b1; tick(1); trig <= 1'b0;
        wait_ev(1'b0, 600); tick(60); `CHK(dones, c0 + 1, "trigger count")
        wb(1'b0, RES, 32'h0);
        `CHK(q[15:0], ({10'h0f3, 6'h06}), "armed result")
        $display("trigger test done");
    endtask

    task t_abort;
        lvl[2] = 10'h155;
        wb(1'b1, CMD, 32'h0d); tick(20); c0 = dones;
        wb(1'b1, CMD, 32'h0a); wait_ev(1'b0, 600); tick(60);
        `CHK(dones, c0 + 1, "abort count")
        wb(1'b0, RES, 32'h0);
        `CHK(q[15:0], ({10'h155, 6'h02}), "abort result")
        $display("abort test done");
    endtask

    task automatic t_test;
        logic [7:0] tv[4] = '{8'h03, 8'h01, 8'h05, 8'h0b};
        logic [9:0] ev[4] = '{10'h3ff, 10'h000, 10'h001, 10'h3fe};
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, TST, {24'h0, tv[i]});
            wb(1'b1, CMD, 32'h0f); wait_ev(1'b0, 600); tick(2);
            `CHK(({ten, vsel}), ({tv[i][0], tv[i][1]}), "test select")
            wb(1'b0, RES, 32'h0); `CHK(q[15:6], ev[i], "test result")
        end
        wb(1'b1, TST, 32'h0);
        $display("test mode test done");
    endtask

    task t_thr;
        lvl[0] = 10'h300;
        lvl[1] = 10'h100;
        wb(1'b1, adc_seq_pkg::IDX_THRESHOLD, 32'h200);
        c0 = dones;
        h0 = hits;
        wb(1'b1, CMD, 32'h28); wait_ev(1'b1, 2000);
        `CHK(hits, h0 + 1, "above")
        wb(1'b1, CMD, 32'h39); wait_ev(1'b1, 2000);
        `CHK(hits, h0 + 2, "below")
        wb(1'b1, CMD, 32'h29); tick(300); `CHK(hits, h0 + 2, "no crossing")
        `CHK(dones, c0, "done in threshold")
        wb(1'b1, CMD, 32'h00);
        $display("threshold test done");
    endtask

    task results;
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Main sequence
    initial begin
        tick(20);
        rst_i <= 1'b0;
        t_regs;
        t_norm;
        t_arm;
        t_abort;
        t_test;
        t_thr;
        results;
    end

    // Watchdog
    initial begin
        tick(20000);
        bad_count++;
        $display("BAD %0t watchdog", $time);
        results;
    end
endmodule
